// >>> fdk_copier.sv
`timescale 1ns/1ps
`include "fdk_params.svh"

module fdk_copier (
    // clock and reset
    input  wire logic                clk_i,
    input  wire logic                rst_n_i,
    // control
    input  wire logic                start_i,
    input  wire logic [23:0]         base_i,
    output logic                     busy_o,
    output logic                     done_o,
    // routine source
    output logic [11:0]              src_addr_o,
    input  wire logic [7:0]          src_data_i,
    // ram write port
    output fdk_pkg::fdk_ram_wr_s     ram_wr_o
);
    import fdk_pkg::*;

    fdk_cp_state_e state_r;
    logic [23:0]   base_r;

    ////////////////////////////////////////////////////////////////////
    // sequencing
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_r    <= FDK_CP_IDLE;
            base_r     <= 24'h000000;
            src_addr_o <= 12'h000;
            busy_o     <= 1'b0;
            done_o     <= 1'b0;
        end else begin
            done_o <= 1'b0;
            case (state_r)
                FDK_CP_IDLE: begin
                    if (start_i) begin
                        state_r    <= FDK_CP_COPY;
                        base_r     <= base_i;
                        src_addr_o <= 12'h000;
                        busy_o     <= 1'b1;
                    end
                end
                FDK_CP_COPY: begin
                    src_addr_o <= src_addr_o + 12'h001;
                    if (src_addr_o == `FDK_DL_LAST) begin
                        state_r <= FDK_CP_IDLE;
                        busy_o  <= 1'b0;
                        done_o  <= 1'b1;
                    end
                end
                default: begin
                    state_r <= FDK_CP_IDLE;
                    busy_o  <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // ram writes, one byte per cycle
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ram_wr_o <= '0;
        end else begin
            ram_wr_o.we <= (state_r == FDK_CP_COPY);
            ram_wr_o.addr <= base_r + {12'h000, src_addr_o};
            ram_wr_o.data <= src_data_i;
        end
    end

endmodule : fdk_copier

// >>> fdk_guard.sv
// How it works
// - erase select bits 7..1 read zero
// - erase select bit 0 writable, resets 0
// - erase select bit cleared when copy ends
// - download request needs key A5
// - flash modify enabled only by key 5A
// - other key values keep flash protected
// - eight-bit key register, resets 00
// - destination: error bit 7, code 6..0
// - code valid only from 00 to 02
// - bad code sets error, download abandoned
// - codes 00/01/02 map to three bases
// - download fills 4 kbytes from base
// - request bit always reads zero; busy shows in irq status bit 2
`timescale 1ns/1ps
`include "fdk_params.svh"

module fdk_guard (
    // clock and reset
    input  wire logic                clk_i,
    input  wire logic                rst_n_i,
    // axi4-lite write address
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [7:0]          s_axi_awaddr,
    // axi4-lite write data
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    // axi4-lite write response
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    output logic [1:0]               s_axi_bresp,
    // axi4-lite read address
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    input  wire logic [7:0]          s_axi_araddr,
    // axi4-lite read data
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    // routine source
    output logic [11:0]              src_addr_o,
    output logic                     src_erase_o,
    input  wire logic [7:0]          src_data_i,
    // ram write port
    output fdk_pkg::fdk_ram_wr_s     ram_wr_o,
    // flash array guard
    output logic                     flash_modify_en_o,
    // interrupt
    output logic                     irq_o
);
    import fdk_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic code_ok(input logic [6:0] code);
        code_ok = (code <= `FDK_DEST_CODE_MAX);
    endfunction : code_ok

    function automatic logic [23:0] code_base(input logic [6:0] code);
        case (code[1:0])
            2'b00:   code_base = `FDK_RAM_BASE_0;
            2'b01:   code_base = `FDK_RAM_BASE_1;
            default: code_base = `FDK_RAM_BASE_2;
        endcase
    endfunction : code_base

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == `FDK_OFS_ERASE_SEL) || (a == `FDK_OFS_FLASH_KEY) ||
                 (a == `FDK_OFS_DEST) || (a == `FDK_OFS_CTRL_STATUS) ||
                 (a == `FDK_OFS_IRQ_STATUS) || (a == `FDK_OFS_IRQ_MASK);
    endfunction : mapped

    ////////////////////////////////////////////////////////////////////
    // state
    logic        aw_held_r;
    logic        w_held_r;
    logic [7:0]  awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0]  wstrb_r;
    logic        erase_pick_r;
    logic [7:0]  key_r;
    fdk_dest_s   dest_r;
    logic [1:0]  irq_stat_r;
    logic [1:0]  irq_mask_r;
    logic        busy;
    logic        done;
    logic        wr_fire;
    logic        wr_lane0;
    logic        rd_fire;
    logic        req_wr;
    logic        dl_start;
    logic        dl_err;
    logic [1:0]  ev;
    logic        stat_clr;
    logic [7:0]  rd_val;

    assign wr_fire  = aw_held_r && w_held_r && !s_axi_bvalid;
    assign wr_lane0 = wr_fire && wstrb_r[0] && mapped(awaddr_r);
    assign rd_fire  = s_axi_arvalid && s_axi_arready;

    ////////////////////////////////////////////////////////////////////
    // axi write channels
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            aw_held_r     <= 1'b0;
            awaddr_r      <= 8'h00;
            s_axi_awready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held_r && !(s_axi_awvalid && s_axi_awready);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_r <= 1'b1;
                awaddr_r  <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_held_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            w_held_r     <= 1'b0;
            wdata_r      <= 32'h00000000;
            wstrb_r      <= 4'h0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_wready <= !w_held_r && !(s_axi_wvalid && s_axi_wready);
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_r <= 1'b1;
                wdata_r  <= s_axi_wdata;
                wstrb_r  <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_held_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `FDK_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= mapped(awaddr_r) ? `FDK_RESP_OKAY
                                             : `FDK_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // axi read channels
    always_comb begin
        rd_val = 8'h00;
        case (s_axi_araddr)
            `FDK_OFS_ERASE_SEL:   rd_val = {7'h00, erase_pick_r};
            `FDK_OFS_FLASH_KEY:   rd_val = key_r;
            `FDK_OFS_DEST:        rd_val = dest_r;
            `FDK_OFS_IRQ_STATUS:  rd_val = {5'h00, busy, irq_stat_r};
            `FDK_OFS_IRQ_MASK:    rd_val = {6'h00, irq_mask_r};
            default:              rd_val = 8'h00;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `FDK_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !rd_fire;
            if (rd_fire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= {24'h000000, rd_val};
                s_axi_rresp  <= mapped(s_axi_araddr) ? `FDK_RESP_OKAY
                                                     : `FDK_RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // download request decode
    assign req_wr = wr_lane0 && (awaddr_r == `FDK_OFS_CTRL_STATUS) &&
                    wdata_r[`FDK_BIT_DL_REQUEST] &&
                    (key_r == `FDK_KEY_DOWNLOAD) && !busy;
    assign dl_start = req_wr && code_ok(dest_r.code);
    assign dl_err   = req_wr && !code_ok(dest_r.code);

    ////////////////////////////////////////////////////////////////////
    // erase routine select
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            erase_pick_r <= 1'(`FDK_RST_ERASE_SEL);
        end else if (wr_lane0 && (awaddr_r == `FDK_OFS_ERASE_SEL)) begin
            erase_pick_r <= wdata_r[`FDK_BIT_ERASE_PICK];
        end else if (done) begin
            erase_pick_r <= 1'b0;
        end
    end

    assign src_erase_o = erase_pick_r;

    ////////////////////////////////////////////////////////////////////
    // key register
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            key_r <= `FDK_RST_FLASH_KEY;
        end else if (wr_lane0 && (awaddr_r == `FDK_OFS_FLASH_KEY)) begin
            key_r <= wdata_r[7:0];
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flash_modify_en_o <= 1'b0;
        end else begin
            flash_modify_en_o <= (key_r == `FDK_KEY_MODIFY);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // transfer destination
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dest_r <= `FDK_RST_DEST;
        end else begin
            if (wr_lane0 && (awaddr_r == `FDK_OFS_DEST)) begin
                dest_r.code <= wdata_r[6:0];
            end
            if (dl_err) begin
                dest_r.err <= 1'b1;
            end else if (wr_lane0 && (awaddr_r == `FDK_OFS_DEST)) begin
                dest_r.err <= wdata_r[`FDK_BIT_DEST_ERR];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // download engine
    fdk_copier u_copier (
        .clk_i      (clk_i),
        .rst_n_i    (rst_n_i),
        .start_i    (dl_start),
        .base_i     (code_base(dest_r.code)),
        .busy_o     (busy),
        .done_o     (done),
        .src_addr_o (src_addr_o),
        .src_data_i (src_data_i),
        .ram_wr_o   (ram_wr_o)
    );

    ////////////////////////////////////////////////////////////////////
    // interrupts
    assign ev = {dl_err, done};
    assign stat_clr = rd_fire && (s_axi_araddr == `FDK_OFS_IRQ_STATUS);

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_stat_r <= 2'b00;
        end else begin
            irq_stat_r <= (stat_clr ? 2'b00 : irq_stat_r) | ev;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_mask_r <= 2'b00;
        end else if (wr_lane0 && (awaddr_r == `FDK_OFS_IRQ_MASK)) begin
            irq_mask_r <= wdata_r[1:0];
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(irq_stat_r & irq_mask_r);
        end
    end

endmodule : fdk_guard

// >>> fdk_guard_asserts.sv
`timescale 1ns/1ps
module fdk_guard_chk
    import fdk_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        rst_n_i,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0]  s_axi_wstrb,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        src_erase_o,
    input fdk_ram_wr_s      ram_wr_o,
    input wire logic        flash_modify_en_o,
    input wire logic        irq_o
);
    logic [7:0]  aw_q, ar_q, wd_q, key_q, dest_q;
    logic        bv_d, ws_q;
    logic [12:0] run;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            {aw_q, ar_q, wd_q, key_q, dest_q} <= 40'h0;
            {bv_d, ws_q} <= 2'b00;
            run <= 13'h0;
        end else begin
            bv_d <= s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
            if (s_axi_wvalid && s_axi_wready)
                {ws_q, wd_q} <= {s_axi_wstrb[0], s_axi_wdata[7:0]};
            if (s_axi_arvalid && s_axi_arready) ar_q <= s_axi_araddr;
            if (s_axi_bvalid && !bv_d && ws_q && aw_q == 8'h04) key_q <= wd_q;
            if (s_axi_bvalid && !bv_d && ws_q && aw_q == 8'h08)
                dest_q <= wd_q;
            run <= ram_wr_o.we ? run + 13'h1 : 13'h0;
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    a_erase_resv: assert property (
        s_axi_rvalid && ar_q == 8'h00 |-> s_axi_rdata[31:1] == 31'h0)
        else $error("erase select upper bits set");
    a_key_read: assert property (
        s_axi_rvalid && ar_q == 8'h04 |-> s_axi_rdata == {24'h0, key_q})
        else $error("key readback wrong");
    a_modify_key: assert property (
        flash_modify_en_o == (key_q == 8'h5a))
        else $error("modify enable does not follow key");
    a_copy_key: assert property (
        $rose(ram_wr_o.we) |-> key_q == 8'ha5)
        else $error("copy without download key");
    a_copy_base: assert property (
        $rose(ram_wr_o.we) |-> dest_q[6:2] == 5'h0 && ram_wr_o.addr
        == 24'hff9000 + {10'h0, dest_q[1:0], 12'h000})
        else $error("copy base wrong");
    a_addr_step: assert property (
        ram_wr_o.we && $past(ram_wr_o.we) |->
        ram_wr_o.addr == $past(ram_wr_o.addr) + 24'h1)
        else $error("ram address not consecutive");
    a_burst_len: assert property (
        $fell(ram_wr_o.we) |-> run == 13'd4096)
        else $error("copy length wrong");
    a_erase_clear: assert property (
        $fell(ram_wr_o.we) |-> ##[0:3] !src_erase_o)
        else $error("erase select not cleared");
    c_copy: cover property ($rose(ram_wr_o.we));
    c_slverr: cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
    c_irq: cover property ($rose(irq_o));
endmodule : fdk_guard_chk
bind fdk_guard fdk_guard_chk u_chk (.clk_i, .rst_n_i, .s_axi_awvalid,
    .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_arvalid,
    .s_axi_arready,
    .s_axi_araddr, .s_axi_rvalid, .s_axi_rdata, .s_axi_rresp,
    .src_erase_o, .ram_wr_o, .flash_modify_en_o, .irq_o);

// >>> fdk_params.svh
`ifndef FDK_PARAMS_SVH
`define FDK_PARAMS_SVH

// register byte offsets
`define FDK_OFS_ERASE_SEL     8'h00
`define FDK_OFS_FLASH_KEY     8'h04
`define FDK_OFS_DEST          8'h08
`define FDK_OFS_CTRL_STATUS   8'h0c
`define FDK_OFS_IRQ_STATUS    8'h10
`define FDK_OFS_IRQ_MASK      8'h14

// field positions
`define FDK_BIT_ERASE_PICK    0
`define FDK_BIT_DL_REQUEST    0
`define FDK_BIT_DEST_ERR      7
`define FDK_BIT_EV_DONE       0
`define FDK_BIT_EV_ERR        1
`define FDK_BIT_BUSY          2

// reset values
`define FDK_RST_ERASE_SEL     8'h00
`define FDK_RST_FLASH_KEY     8'h00
`define FDK_RST_DEST          8'h00

// key codes
`define FDK_KEY_DOWNLOAD      8'ha5
`define FDK_KEY_MODIFY        8'h5a

// destination codes and ram start addresses
`define FDK_DEST_CODE_MAX     7'h02
`define FDK_RAM_BASE_0        24'hff9000
`define FDK_RAM_BASE_1        24'hffa000
`define FDK_RAM_BASE_2        24'hffb000

// download length: 4 kbytes
`define FDK_DL_LAST           12'hfff

// axi responses
`define FDK_RESP_OKAY         2'b00
`define FDK_RESP_SLVERR       2'b10

`endif

// >>> fdk_pkg.sv
package fdk_pkg;

    typedef enum logic {
        FDK_CP_IDLE,
        FDK_CP_COPY
    } fdk_cp_state_e;

    typedef struct packed {
        logic        we;
        logic [23:0] addr;
        logic [7:0]  data;
    } fdk_ram_wr_s;

    typedef struct packed {
        logic        err;
        logic [6:0]  code;
    } fdk_dest_s;

endpackage : fdk_pkg

// >>> flash_download_key_guard_test.sv
`timescale 1ns/1ps
module flash_download_key_guard_test;
    import fdk_pkg::*;
    logic clk_i, rst_n_i, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready, src_erase_o;
    logic flash_modify_en_o, irq_o;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, src_data_i, salt, k;
    logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
    logic [11:0] src_addr_o;
    fdk_ram_wr_s ram_wr_o;
    int error_cnt, samples_checked, wr_cnt, n;
    int exp_base;
    fdk_guard u_dut (.*);
    assign src_data_i = src_addr_o[7:0] ^ salt;
    always #12.5 clk_i = ~clk_i;
    task automatic final_report();
        $display("checks=%0d errors=%0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : final_report
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ah, wh, fin;
        fin = 1'b0;
        @(posedge clk_i);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!fin) begin
            @(negedge clk_i);
            ah = s_axi_awvalid && s_axi_awready;
            wh = s_axi_wvalid && s_axi_wready;
            fin = s_axi_bvalid;
            rsp = s_axi_bresp;
            @(posedge clk_i);
            if (ah) s_axi_awvalid <= 1'b0;
            if (wh) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        logic ah, fin;
        fin = 1'b0;
        @(posedge clk_i);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!fin) begin
            @(negedge clk_i);
            ah = s_axi_arvalid && s_axi_arready;
            fin = s_axi_rvalid;
            rdat = s_axi_rdata;
            rsp = s_axi_rresp;
            @(posedge clk_i);
            if (ah) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
    endtask : rd
    // ram write monitor against expected base and source bytes
    always @(negedge clk_i) begin
        if (ram_wr_o.we === 1'b1) begin
            check(32'(ram_wr_o.addr), exp_base + wr_cnt);
            check(32'(ram_wr_o.data), 32'(8'(wr_cnt) ^ salt));
            wr_cnt++;
        end
    end
    initial begin
        repeat (40000) @(posedge clk_i);
        error_cnt++;
        final_report();
    end
    initial begin
        {clk_i, rst_n_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h0;
        {s_axi_wdata, s_axi_wstrb, salt, exp_base, wr_cnt} = 0;
        s_axi_wstrb = 4'h1;
        void'($urandom(32'h90b9));
        repeat (20) @(posedge clk_i);
        rst_n_i <= 1'b1;
        salt <= 8'($urandom);
        for (int i = 0; i < 6; i++) begin
            rd(8'(i * 4));
            check(rdat, 32'h0);
        end
        $display("done: reset values");
        wr(8'h00, 32'hffffffff);
        rd(8'h00);
        check(rdat, 32'h1);
        check(32'(src_erase_o), 32'h1);
        $display("done: erase select");
        for (int i = 0; i < 10; i++) begin
            k = (i == 8) ? 8'h5a : (i == 9) ? 8'ha5 : 8'($urandom);
            wr(8'h04, 32'(k));
            rd(8'h04);
            check(rdat, 32'(k));
            check(32'(flash_modify_en_o), 32'(k == 8'h5a));
        end
        s_axi_wstrb <= 4'h0;
        wr(8'h04, 32'h33);
        s_axi_wstrb <= 4'h1;
        rd(8'h04);
        check(rdat, 32'ha5);
        $display("done: key");
        wr(8'h14, 32'h1);
        k = 8'($urandom);
        if (k == 8'ha5) k = 8'h5a;
        wr(8'h04, 32'(k));
        wr(8'h0c, 32'h1);
        rd(8'h10);
        check(rdat, 32'h0);
        check(wr_cnt, 0);
        $display("done: locked request");
        for (int c = 0; c < 3; c++) begin
            wr(8'h08, 32'(c));
            wr(8'h04, 32'ha5);
            wr(8'h00, 32'h1);
            exp_base = 32'hff9000 + c * 4096;
            wr_cnt = 0;
            wr(8'h0c, 32'h1);
            rd(8'h10);
            check(rdat, 32'h4);
            n = 0;
            while (wr_cnt < 4096 && n < 6000) begin
                @(posedge clk_i);
                n++;
            end
            repeat (4) @(posedge clk_i);
            check(wr_cnt, 4096);
            check(32'(irq_o), 32'h1);
            rd(8'h10);
            check(rdat, 32'h1);
            rd(8'h00);
            check(rdat, 32'h0);
            check(32'(irq_o), 32'h0);
        end
        $display("done: downloads");
        k = 8'(3 + $urandom % 125);
        wr(8'h08, 32'(k));
        wr_cnt = 0;
        wr(8'h0c, 32'h1);
        rd(8'h08);
        check(rdat, 32'(k | 8'h80));
        check(32'(irq_o), 32'h0);
        rd(8'h10);
        check(rdat, 32'h2);
        wr(8'h0c, 32'h1);
        rd(8'h08);
        check(rdat, 32'(k | 8'h80));
        check(wr_cnt, 0);
        wr(8'h08, 32'h1);
        rd(8'h08);
        check(rdat, 32'h1);
        $display("done: bad destination");
        rd(8'h40);
        check(rdat, 32'h0);
        check(32'(rsp), 32'h2);
        wr(8'h40, 32'hff);
        check(32'(rsp), 32'h2);
        $display("done: unmapped");
        final_report();
    end
endmodule : flash_download_key_guard_test
